// ### rtl/eik_top.sv
// external interrupt, key wakeup and port A pin logic with AXI4-Lite regs
// ==========================================================
// What this block does
// - falling edge on the external interrupt pin sets the external flag.
// - external request needs flag, its enable, and CPU mask clear.
// - external flag is read-only; cleared by its clear bit or reset.
// - unused status bits 6-5 and 2-1 read zero, writes ignored.
// - falling edge on an enabled key wakeup pin sets the key flag.
// - key wakeup request needs key flag and key global enable.
// - key flag is read-only; cleared by its clear bit or reset.
// - clear bits are write-only, read zero; one clears, zero ignored.
// - serial byte interrupt needs mask clear and enable; vector 1FF2.
// - event counter interrupt needs mask clear; vector 1FF4.
// - time base interrupt needs mask clear; vector 1FF0.
// - key wakeup interrupt needs mask clear; vector 1FF8.
// - enabling a pending external or key interrupt delays one instruction.
// - direction bit one means output; reset clears all direction bits.
// - outputs driven from latch; input lines read the live pin.
// - data at offset zero, direction there in option map; latch not reset.
// - two select bits enable pullups; reset leaves pullups off.
// - lines 0-3 always open drain; 4-7 only with select bit set.
// - four key latches catch falling edges, cleared with the key flag.
// - sense select zero is low level plus edge, one edge only.
// - both enable bits sit in control register, reset to zero.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module eik_top
  import eik_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_int_pin,
  input  wire logic [PA_W-1:0]   pa_in,
  output logic [PA_W-1:0]        pa_out,
  output logic [PA_W-1:0]        pa_oe_n,
  output logic [PA_W-1:0]        pa_pullup_en,
  input  wire logic              cpu_int_mask,
  input  wire logic              insn_done,
  input  wire logic              serial_interrupt,
  input  wire logic              serial_int_enable,
  input  wire logic              event_count_interrupt,
  input  wire logic              time_base_interrupt,
  output logic                   int_request,
  output logic [15:0]            int_vector
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [PA_W-1:0]     pa_s1;
    logic [PA_W-1:0]     pa_s2;
    logic [PA_W-1:0]     pa_prev;
    logic                irq_s1;
    logic                irq_s2;
    logic                irq_prev;
    logic [PA_W-1:0]     dir;
    logic [KW_LINES-1:0] pin_en;
    logic                ext_en;
    logic                kw_en;
    logic                sense_sel;
    logic                pu_hi;
    logic                pu_lo;
    logic                od_hi_sel;
    logic                opt_map;
    logic                ext_flag;
    logic                kw_flag;
    logic [KW_LINES-1:0] kw_latch;
    logic [1:0]          ext_hold;
    logic [1:0]          kw_hold;
    logic                irq_req;
    logic [15:0]         vector;
    logic [PA_W-1:0]     pa_out;
    logic [PA_W-1:0]     pa_oe_n;
    logic [PA_W-1:0]     pa_pu;
    logic                aw_full;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_full;
    logic [7:0]          w_byte;
    logic                w_lane0;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } eik_state_s;

  eik_state_s st_q;
  eik_state_s st_d;
  // the data latch is deliberately left out of reset
  logic [PA_W-1:0] data_latch_q;
  logic [PA_W-1:0] data_latch_d;
  logic            ext_fall;
  logic [KW_LINES-1:0] kw_fall;
  logic            clr_ext;
  logic            clr_kw;
  logic            do_write;
  logic [7:0]      status_word;

  // ==========================================================
  // decode helpers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    is_mapped = (o == OFF_PORT_A) || (o == OFF_INT_CTRL) ||
                (o == OFF_INT_STAT) || (o == OFF_KW_PIN_EN) ||
                (o == OFF_PULLUP) || (o == OFF_OPEN_DRN) ||
                (o == OFF_MAP_SEL);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (8'(a) == off);
  endfunction

  // ==========================================================
  // combinational next state
  always_comb begin
    st_d = st_q;
    data_latch_d = data_latch_q;
    // two-stage synchronisers; edge detect looks only at stage two
    st_d.pa_s1 = pa_in;
    st_d.pa_s2 = st_q.pa_s1;
    st_d.pa_prev = st_q.pa_s2;
    st_d.irq_s1 = ext_int_pin;
    st_d.irq_s2 = st_q.irq_s1;
    st_d.irq_prev = st_q.irq_s2;
    ext_fall = st_q.irq_prev & ~st_q.irq_s2;
    kw_fall = st_q.pin_en & st_q.pa_prev[KW_LINES-1:0] &
              ~st_q.pa_s2[KW_LINES-1:0];

    // ---- AXI write channel capture
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_full = 1'b1;
      st_d.w_byte = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    do_write = st_q.aw_full && st_q.w_full && !st_q.bvalid;
    clr_ext = 1'b0;
    clr_kw = 1'b0;
    if (do_write) begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = is_mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.w_lane0) begin
        if (hit(st_q.aw_addr, OFF_PORT_A)) begin
          if (st_q.opt_map)
            st_d.dir = st_q.w_byte;
          else
            data_latch_d = st_q.w_byte;
        end
        if (hit(st_q.aw_addr, OFF_INT_CTRL)) begin
          st_d.ext_en = st_q.w_byte[CTL_EXT_EN];
          st_d.kw_en = st_q.w_byte[CTL_KW_EN];
          st_d.sense_sel = st_q.w_byte[CTL_SENSE];
          // a fresh enable holds the request back for two insns
          if (st_q.w_byte[CTL_EXT_EN] && !st_q.ext_en)
            st_d.ext_hold = HOLD_INSNS;
          if (st_q.w_byte[CTL_KW_EN] && !st_q.kw_en)
            st_d.kw_hold = HOLD_INSNS;
        end
        if (hit(st_q.aw_addr, OFF_INT_STAT)) begin
          // only the clear bits act; flags and spare bits ignore writes
          clr_ext = st_q.w_byte[STA_EXT_CLR];
          clr_kw = st_q.w_byte[STA_KW_CLR];
        end
        if (hit(st_q.aw_addr, OFF_KW_PIN_EN))
          st_d.pin_en = st_q.w_byte[KW_LINES-1:0];
        if (hit(st_q.aw_addr, OFF_PULLUP)) begin
          st_d.pu_lo = st_q.w_byte[PU_LOW_SEL];
          st_d.pu_hi = st_q.w_byte[PU_HIGH_SEL];
        end
        if (hit(st_q.aw_addr, OFF_OPEN_DRN))
          st_d.od_hi_sel = st_q.w_byte[OD_SEL];
        if (hit(st_q.aw_addr, OFF_MAP_SEL))
          st_d.opt_map = st_q.w_byte[MAP_OPTION];
      end
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    st_d.awready = !st_d.aw_full && !st_d.bvalid;
    st_d.wready = !st_d.w_full && !st_d.bvalid;

    // ---- flags: clear first, so a new event in the same cycle wins
    if (clr_ext)
      st_d.ext_flag = 1'b0;
    if (clr_kw) begin
      st_d.kw_flag = 1'b0;
      st_d.kw_latch = '0;
    end
    // level mode keeps setting the flag while the pin stays low
    if (ext_fall || (!st_q.sense_sel && !st_q.irq_s2))
      st_d.ext_flag = 1'b1;
    st_d.kw_latch = st_d.kw_latch | kw_fall;
    if (|kw_fall)
      st_d.kw_flag = 1'b1;

    // instruction-boundary hold after enabling
    if (insn_done && st_q.ext_hold != 2'h0)
      st_d.ext_hold = st_d.ext_hold - 2'h1;
    if (insn_done && st_q.kw_hold != 2'h0)
      st_d.kw_hold = st_d.kw_hold - 2'h1;

    // ---- request and vector, highest vector first
    st_d.irq_req = 1'b0;
    st_d.vector = VEC_NONE;
    if (!cpu_int_mask) begin
      if (st_q.ext_flag && st_q.ext_en && st_q.ext_hold == 2'h0) begin
        st_d.irq_req = 1'b1;
        st_d.vector = VEC_EXT;
      end else if (st_q.kw_flag && st_q.kw_en &&
                   st_q.kw_hold == 2'h0) begin
        st_d.irq_req = 1'b1;
        st_d.vector = VEC_KW;
      end else if (event_count_interrupt) begin
        st_d.irq_req = 1'b1;
        st_d.vector = VEC_EVENT;
      end else if (serial_interrupt && serial_int_enable) begin
        st_d.irq_req = 1'b1;
        st_d.vector = VEC_SERIAL;
      end else if (time_base_interrupt) begin
        st_d.irq_req = 1'b1;
        st_d.vector = VEC_TBASE;
      end
    end

    // pin drivers; open drain releases on a one
    for (int i = 0; i < PA_W; i++) begin
      st_d.pa_out[i] = data_latch_d[i];
      if (!st_d.dir[i])
        st_d.pa_oe_n[i] = 1'b1;
      else if (i < OD_FIXED || st_d.od_hi_sel)
        st_d.pa_oe_n[i] = data_latch_d[i];
      else
        st_d.pa_oe_n[i] = 1'b0;
      st_d.pa_pu[i] = (i < OD_FIXED) ? st_d.pu_lo : st_d.pu_hi;
    end

    // ---- AXI read channel
    status_word = BYTE_ZERO;
    status_word[STA_EXT_FLAG] = st_q.ext_flag;
    status_word[STA_KW_FLAG] = st_q.kw_flag;
    if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = '0;
      st_d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (hit(s_axi_araddr, OFF_PORT_A))
        st_d.rdata[7:0] = st_q.opt_map ? st_q.dir :
          ((data_latch_q & st_q.dir) | (st_q.pa_s2 & ~st_q.dir));
      if (hit(s_axi_araddr, OFF_INT_CTRL)) begin
        st_d.rdata[CTL_EXT_EN] = st_q.ext_en;
        st_d.rdata[CTL_KW_EN] = st_q.kw_en;
        st_d.rdata[CTL_SENSE] = st_q.sense_sel;
      end
      if (hit(s_axi_araddr, OFF_INT_STAT))
        st_d.rdata[7:0] = status_word;
      if (hit(s_axi_araddr, OFF_KW_PIN_EN))
        st_d.rdata[KW_LINES-1:0] = st_q.pin_en;
      if (hit(s_axi_araddr, OFF_PULLUP)) begin
        st_d.rdata[PU_LOW_SEL] = st_q.pu_lo;
        st_d.rdata[PU_HIGH_SEL] = st_q.pu_hi;
      end
      if (hit(s_axi_araddr, OFF_OPEN_DRN))
        st_d.rdata[OD_SEL] = st_q.od_hi_sel;
      if (hit(s_axi_araddr, OFF_MAP_SEL))
        st_d.rdata[MAP_OPTION] = st_q.opt_map;
    end
    st_d.arready = !st_d.rvalid;
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.pa_oe_n <= BYTE_ONES;
      st_q.pa_s1 <= BYTE_ONES;
      st_q.pa_s2 <= BYTE_ONES;
      st_q.pa_prev <= BYTE_ONES;
      st_q.irq_s1 <= 1'b1;
      st_q.irq_s2 <= 1'b1;
      st_q.irq_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // survives reset; contents are undefined only at power-up
  always_ff @(posedge core_clk) begin
    data_latch_q <= data_latch_d;
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign pa_out        = st_q.pa_out;
  assign pa_oe_n       = st_q.pa_oe_n;
  assign pa_pullup_en  = st_q.pa_pu;
  assign int_request   = st_q.irq_req;
  assign int_vector    = st_q.vector;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_kw_enable_rise;
    !st_q.kw_en ##1 st_q.kw_en && st_q.kw_flag;
  endsequence

  a_ext_edge_set: assert property (
    ext_fall |=> st_q.ext_flag)
    else $error("falling edge did not set external flag");
  a_ext_req_gate: assert property (
    int_request && int_vector == VEC_EXT |->
      $past(st_q.ext_flag && st_q.ext_en && !cpu_int_mask))
    else $error("external request without its conditions");
  a_ext_flag_keep: assert property (
    st_q.ext_flag && !clr_ext |=> st_q.ext_flag)
    else $error("external flag dropped without clear");
  a_status_spare: assert property (
    $rose(s_axi_rvalid) && $past(hit(s_axi_araddr, OFF_INT_STAT)) |->
      s_axi_rdata[6:5] == 2'h0 && s_axi_rdata[2:1] == 2'h0 &&
      s_axi_rdata[STA_EXT_CLR] == 1'b0 && s_axi_rdata[STA_KW_CLR] == 1'b0)
    else $error("status spare or clear bits read non-zero");
  a_kw_edge_set: assert property (
    |kw_fall |=> st_q.kw_flag && |st_q.kw_latch)
    else $error("key edge did not set key flag");
  a_kw_req_gate: assert property (
    int_request && int_vector == VEC_KW |->
      $past(st_q.kw_flag && st_q.kw_en && !cpu_int_mask))
    else $error("key request without its conditions");
  a_clear_works: assert property (
    clr_kw && kw_fall == '0 |=> !st_q.kw_flag && st_q.kw_latch == '0)
    else $error("key clear did not clear flag and latches");
  a_enable_delay: assert property (
    s_kw_enable_rise |-> !(int_request && int_vector == VEC_KW) [*2])
    else $error("key request not delayed after enable");
  a_low_nibble_od: assert property (
    ((~pa_oe_n[OD_FIXED-1:0]) & pa_out[OD_FIXED-1:0]) == '0)
    else $error("low nibble drove a high level");
  a_input_float: assert property (
    $past(st_d.dir) == BYTE_ZERO |-> pa_oe_n == BYTE_ONES)
    else $error("input line was driven");

endmodule // eik_top
`default_nettype wire

// ### include/eik_pkg.sv
// constants for the external interrupt, key wakeup and port A block
`default_nettype none
package eik_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_PORT_A    = 8'h00; // data, or direction
  localparam logic [7:0] OFF_INT_CTRL  = 8'h04;
  localparam logic [7:0] OFF_INT_STAT  = 8'h08;
  localparam logic [7:0] OFF_KW_PIN_EN = 8'h0C;
  localparam logic [7:0] OFF_PULLUP    = 8'h10;
  localparam logic [7:0] OFF_OPEN_DRN  = 8'h14;
  localparam logic [7:0] OFF_MAP_SEL   = 8'h18;
  // ==========================================================
  // field positions
  localparam int CTL_EXT_EN   = 7;
  localparam int CTL_KW_EN    = 4;
  localparam int CTL_SENSE    = 3;
  localparam int STA_EXT_FLAG = 7;
  localparam int STA_KW_FLAG  = 4;
  localparam int STA_EXT_CLR  = 3;
  localparam int STA_KW_CLR   = 0;
  localparam int PU_LOW_SEL   = 0;
  localparam int PU_HIGH_SEL  = 1;
  localparam int OD_SEL       = 0;
  localparam int MAP_OPTION   = 0;
  localparam int KW_LINES     = 4;
  localparam int OD_FIXED     = 4;  // lines below this are always open drain
  localparam int PA_W         = 8;
  // ==========================================================
  // interrupt vectors, high byte address of each pair's first word
  localparam logic [15:0] VEC_EXT    = 16'h1FFA;
  localparam logic [15:0] VEC_KW     = 16'h1FF8;
  localparam logic [15:0] VEC_EVENT  = 16'h1FF4;
  localparam logic [15:0] VEC_SERIAL = 16'h1FF2;
  localparam logic [15:0] VEC_TBASE  = 16'h1FF0;
  localparam logic [15:0] VEC_NONE   = 16'h0000;
  // ==========================================================
  // misc
  localparam logic [1:0] HOLD_INSNS = 2'h2;  // enabling insn plus one more
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] BYTE_ONES  = 8'hFF;
endpackage
`default_nettype wire

// ### tb/eik_pin_model.sv
// far-side model: port A wires and cpu instruction boundaries
`timescale 1ns/1ns
`default_nettype none
module eik_pin_model #(
  parameter int INSN_CYC = 8
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe_n,
  input  wire logic [7:0] pa_pullup_en,
  input  wire logic [7:0] ext_lvl,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pa_in,
  output logic            insn_done
);
  logic [7:0] last_q;
  int         cnt_q;
  // ==========================================================
  // wire level
  // a released line with no pullup flips, so nothing leans on it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pa_oe_n[i])
        pa_in[i] = pa_out[i];
      else if (ext_en[i])
        pa_in[i] = ext_lvl[i];
      else
        pa_in[i] = pa_pullup_en[i] | ~last_q[i];
    end
  end
  // ==========================================================
  // instruction boundaries
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_q    <= 8'h00;
      cnt_q     <= 0;
      insn_done <= 1'b0;
    end else begin
      last_q    <= pa_in;
      cnt_q     <= (cnt_q == INSN_CYC - 1) ? 0 : cnt_q + 1;
      insn_done <= (cnt_q == INSN_CYC - 1);
    end
  end
endmodule // eik_pin_model
`default_nettype wire

// ### tb/eik_top_test.sv
// self-checking bench for the interrupt, key wakeup and port A block
`timescale 1ns/1ns
`default_nettype none
module eik_top_test
  import eik_pkg::*;
;
  logic        core_clk, rst, ext_int_pin, cpu_int_mask, insn_done;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, int_request;
  logic [7:0]  pa_in, pa_out, pa_oe_n, pa_pullup_en, ext_lvl, ext_drv;
  logic        serial_interrupt, serial_int_enable;
  logic        event_count_interrupt, time_base_interrupt;
  logic [15:0] int_vector;
  int          failures, n_tests;
  // {serial, serial enable, event, time base, mask}
  logic [4:0]  pst [6] = '{5'h18, 5'h10, 5'h04, 5'h02, 5'h1E, 5'h1F};
  logic [15:0] pvec [6] = '{VEC_SERIAL, VEC_NONE, VEC_EVENT, VEC_TBASE,
                            VEC_EVENT, VEC_NONE};

  eik_top eik_top_inst (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_int_pin, .pa_in,
    .pa_out, .pa_oe_n, .pa_pullup_en, .cpu_int_mask, .insn_done,
    .serial_interrupt, .serial_int_enable, .event_count_interrupt,
    .time_base_interrupt, .int_request, .int_vector);
  eik_pin_model eik_pin_model_inst (.core_clk, .rst, .pa_out, .pa_oe_n,
    .pa_pullup_en, .ext_lvl, .ext_en(ext_drv), .pa_in, .insn_done);

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // ==========================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] st = 4'h1);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    // bready stays up: lowering it would clash with the next call's raise
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
    chk("rdata", {24'h0, e}, s_axi_rdata);
  endtask
  task automatic chkirq(input logic r, input logic [15:0] v);
    chk("int_request", {31'h0, r}, {31'h0, int_request});
    chk("int_vector", {16'h0, v}, {16'h0, int_vector});
  endtask
  // outputs may trail the commit edge by a register stage
  task automatic pins(input logic [7:0] oe, input logic [7:0] pu);
    cyc(2);
    chk("pa_oe_n", {24'h0, oe}, {24'h0, pa_oe_n});
    chk("pa_pullup_en", {24'h0, pu}, {24'h0, pa_pullup_en});
  endtask
  task automatic rst_chk();
    pins(8'hFF, 8'h00);
    chkirq(1'b0, VEC_NONE);
    rd(OFF_INT_CTRL, 8'h00);
    rd(OFF_INT_STAT, 8'h00);
    rd(OFF_PULLUP, 8'h00);
    rd(OFF_OPEN_DRN, 8'h00);
    wr(OFF_MAP_SEL, 8'h01);
    rd(OFF_PORT_A, 8'h00);
    wr(OFF_MAP_SEL, 8'h00);
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize();
  end

  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    ext_int_pin = 1'b1;
    ext_lvl = 8'hF3;
    ext_drv = 8'hFF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, cpu_int_mask, serial_interrupt} = '0;
    {serial_int_enable, event_count_interrupt, time_base_interrupt} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    failures = 0;
    n_tests = 0;
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    rst_chk();
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    rd(8'h1C, 8'h00, RESP_SLVERR);
    wr(OFF_PULLUP, 8'h01);
    pins(8'hFF, 8'h0F);
    wr(OFF_PULLUP, 8'h02);
    pins(8'hFF, 8'hF0);
    // undriven high lines now rest on the pullups alone
    ext_drv <= 8'h0F;
    cyc(3);
    rd(OFF_PORT_A, 8'hF3);
    ext_drv <= 8'hFF;
    wr(OFF_PULLUP, 8'h00);
    wr(OFF_PORT_A, 8'h5A);
    cyc(1);
    chk("pa_out", 32'h5A, {24'h0, pa_out});
    wr(OFF_MAP_SEL, 8'h01);
    wr(OFF_PORT_A, 8'hF0);
    rd(OFF_PORT_A, 8'hF0);
    pins(8'h0F, 8'h00);
    wr(OFF_MAP_SEL, 8'h00);
    rd(OFF_PORT_A, 8'h53);
    wr(OFF_MAP_SEL, 8'h01);
    wr(OFF_PORT_A, 8'hFF);
    pins(8'h0A, 8'h00);
    wr(OFF_OPEN_DRN, 8'h01);
    pins(8'h5A, 8'h00);
    wr(OFF_PORT_A, 8'h00, RESP_OKAY, 4'h0);
    rd(OFF_PORT_A, 8'hFF);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk("pa_out", 32'h5A, {24'h0, pa_out});
    rst_chk();
    // external interrupt, edge mode first
    wr(OFF_INT_STAT, 8'h09);
    wr(OFF_INT_CTRL, 8'h08);
    ext_int_pin <= 1'b0;
    cyc(5);
    rd(OFF_INT_STAT, 8'h80);
    chkirq(1'b0, VEC_NONE);
    wr(OFF_INT_STAT, 8'h00);
    rd(OFF_INT_STAT, 8'h80);
    wr(OFF_INT_STAT, 8'hF6);
    rd(OFF_INT_STAT, 8'h80);
    cpu_int_mask <= 1'b1;
    wr(OFF_INT_CTRL, 8'h88);
    cyc(20);
    chkirq(1'b0, VEC_NONE);
    wr(OFF_INT_CTRL, 8'h08);
    cpu_int_mask <= 1'b0;
    wr(OFF_INT_CTRL, 8'h88);
    cyc(3);
    chkirq(1'b0, VEC_NONE);
    cyc(20);
    chkirq(1'b1, VEC_EXT);
    wr(OFF_INT_STAT, 8'h08);
    rd(OFF_INT_STAT, 8'h00);
    chkirq(1'b0, VEC_NONE);
    ext_int_pin <= 1'b1;
    wr(OFF_INT_CTRL, 8'h00);
    ext_int_pin <= 1'b0;
    cyc(5);
    wr(OFF_INT_STAT, 8'h08);
    rd(OFF_INT_STAT, 8'h80);
    ext_int_pin <= 1'b1;
    cyc(5);
    wr(OFF_INT_STAT, 8'h08);
    rd(OFF_INT_STAT, 8'h00);
    // key wakeup, only line 0 enabled
    wr(OFF_KW_PIN_EN, 8'h01);
    ext_lvl <= 8'hFF;
    cyc(5);
    ext_lvl <= 8'hFB;
    cyc(5);
    rd(OFF_INT_STAT, 8'h00);
    ext_lvl <= 8'hFA;
    cyc(5);
    rd(OFF_INT_STAT, 8'h10);
    wr(OFF_INT_CTRL, 8'h10);
    cyc(20);
    chkirq(1'b1, VEC_KW);
    cpu_int_mask <= 1'b1;
    cyc(3);
    chkirq(1'b0, VEC_NONE);
    cpu_int_mask <= 1'b0;
    ext_int_pin <= 1'b0;
    cyc(5);
    chkirq(1'b1, VEC_KW);
    wr(OFF_INT_CTRL, 8'h90);
    cyc(20);
    chkirq(1'b1, VEC_EXT);
    ext_int_pin <= 1'b1;
    cyc(5);
    wr(OFF_INT_STAT, 8'h09);
    rd(OFF_INT_STAT, 8'h00);
    chkirq(1'b0, VEC_NONE);
    ext_lvl <= 8'hFF;
    cyc(5);
    ext_lvl <= 8'hFE;
    cyc(5);
    rd(OFF_INT_STAT, 8'h10);
    wr(OFF_INT_STAT, 8'h01);
    wr(OFF_INT_CTRL, 8'h00);
    // peripheral sources and their priority
    for (int i = 0; i < 6; i++) begin
      {serial_interrupt, serial_int_enable, event_count_interrupt,
       time_base_interrupt, cpu_int_mask} <= pst[i];
      cyc(3);
      chkirq(pvec[i] != VEC_NONE, pvec[i]);
    end
    summarize();
  end
endmodule // eik_top_test
`default_nettype wire
